// [core/rsc_pkg.sv]
// Package with register map, codes, reset values and timing counts of the reset controller.
package rsc_pkg;

    // ------------------------------------------------------------
    // Register offsets (byte addresses on the AXI4-Lite bus)
    // ------------------------------------------------------------
    localparam logic [3:0] ADDR_PIN_GUARD = 4'h0; // Pin function guard register.
    localparam logic [3:0] ADDR_TRIP_FLAGS = 4'h4; // Trip flag register.
    localparam logic [3:0] ADDR_THRESHOLD = 4'h8; // Threshold select register.
    localparam logic [3:0] ADDR_STATUS = 4'hc; // Read-only state of the sequencer.

    // ------------------------------------------------------------
    // Codes and reset values
    // ------------------------------------------------------------
    localparam logic [7:0] PIN_CODE_IO = 8'h55; // Shared pin is plain I/O.
    localparam logic [7:0] PIN_CODE_CLEAR = 8'haa; // Shared pin is the external clear input.
    localparam logic [7:0] PIN_GUARD_RESET = 8'h55; // Reset value of the pin guard.
    localparam logic [7:0] THR_CODE_2V10 = 8'h55; // 2.1 V threshold.
    localparam logic [7:0] THR_CODE_2V55 = 8'h33; // 2.55 V threshold.
    localparam logic [7:0] THR_CODE_3V15 = 8'h99; // 3.15 V threshold.
    localparam logic [7:0] THR_CODE_3V80 = 8'haa; // 3.8 V threshold.
    localparam logic [7:0] THR_RESET = 8'h55; // Power-on value of the threshold select.
    localparam logic [7:0] PORT_RESET = 8'hff; // Port data and control power-up value.

    // ------------------------------------------------------------
    // Trip flag bit positions
    // ------------------------------------------------------------
    localparam int FLAG_WDOG_BIT = 0; // Watchdog code trip flag.
    localparam int FLAG_THR_BIT = 1; // Threshold code trip flag.
    localparam int FLAG_UV_BIT = 2; // Undervoltage trip flag.
    localparam int FLAG_PIN_BIT = 3; // Pin code trip flag.

    // ------------------------------------------------------------
    // Timing
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 250; // System clock rate in MHz.
    localparam int HOLD_LONG_MS = 48; // Start-up hold after power-on, undervoltage and every other internal reset.
    localparam int HOLD_SHORT_MS = 16; // Start-up hold after the external clear pin.
    localparam int HOLD_LONG_CYC = HOLD_LONG_MS * CLK_MHZ * 1000;
    localparam int HOLD_SHORT_CYC = HOLD_SHORT_MS * CLK_MHZ * 1000;
    localparam int GUARD_TRIP_CYC = 16; // Default guard trip delay in cycles.
    localparam int DEBOUNCE_CYC = 64; // Default undervoltage debounce in cycles.

    // Sequencer states, Gray coded along reset -> hold -> run.
    typedef enum logic [1:0]
    {
        RSC_RESET = 2'b00,
        RSC_HOLD = 2'b01,
        RSC_RUN = 2'b11
    } rsc_state_t;

endpackage

// [core/rsc_reset_controller.sv]
// Reset source controller with AXI4-Lite registers and start-up hold sequencing.
`timescale 1ns/100ps
// ------------------------------------------------------------
// ------------------------------------------------------------
module rsc_reset_controller
    import rsc_pkg::*;
#(
    parameter int HOLD_LONG = HOLD_LONG_CYC, // Long start-up hold in cycles.
    parameter int HOLD_SHORT = HOLD_SHORT_CYC, // Short start-up hold in cycles.
    parameter int GUARD_TRIP = GUARD_TRIP_CYC, // Guard trip delay in cycles.
    parameter int DEBOUNCE = DEBOUNCE_CYC // Undervoltage debounce in cycles.
)
(
    input wire logic MCLK, // System clock.
    input wire logic RSTN, // Power-on reset, synchronous, active low.
    input wire logic EXTERNAL_CLEAR_PIN_N, // External clear pin, active low.
    input wire logic SUPPLY_LOW, // Comparator says supply below threshold.
    input wire logic POWER_DOWN, // Device is in power-down mode.
    input wire logic WATCHDOG_CODE_BAD, // Watchdog enable code invalid.
    input wire logic WATCHDOG_TIMEOUT, // Watchdog time-out warm reset request.
    input wire logic PIN_SHARE_OUT, // Other pin-sharing function output value.
    input wire logic PIN_SHARE_OE, // Other pin-sharing function output enable.
    input wire logic [3:0] S_AXI_AWADDR,
    input wire logic S_AXI_AWVALID,
    output logic S_AXI_AWREADY,
    input wire logic [31:0] S_AXI_WDATA,
    input wire logic [3:0] S_AXI_WSTRB,
    input wire logic S_AXI_WVALID,
    output logic S_AXI_WREADY,
    output logic [1:0] S_AXI_BRESP,
    output logic S_AXI_BVALID,
    input wire logic S_AXI_BREADY,
    input wire logic [3:0] S_AXI_ARADDR,
    input wire logic S_AXI_ARVALID,
    output logic S_AXI_ARREADY,
    output logic [31:0] S_AXI_RDATA,
    output logic [1:0] S_AXI_RRESP,
    output logic S_AXI_RVALID,
    input wire logic S_AXI_RREADY,
    output logic CORE_RESET_N, // Low while the core is held in reset.
    output logic PC_CLEAR, // Program counter forced to zero.
    output logic PORT_INIT, // Port data and control load all ones.
    output logic [7:0] PORT_INIT_VALUE, // Value loaded into port registers.
    output logic PIN_OUT, // Shared pin output value.
    output logic PIN_OE, // Shared pin output enable, high when driving.
    output logic [1:0] THRESHOLD_LEVEL // Selected threshold voltage index.
);

    // ------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------
    logic [1:0] clr_sync; // Clear pin synchroniser; bit 0 is the first stage.
    logic [1:0] low_sync; // Supply comparator synchroniser.

    // The pin and comparator are asynchronous; the first stage feeds only the second.
    always_ff @(posedge MCLK)
    begin
        if (!RSTN)
        begin
            clr_sync <= 2'b11;
            low_sync <= 2'b00;
        end
        else
        begin
            clr_sync <= {clr_sync[0], EXTERNAL_CLEAR_PIN_N};
            low_sync <= {low_sync[0], SUPPLY_LOW};
        end
    end

    // ------------------------------------------------------------
    // Registers and decode
    // ------------------------------------------------------------
    logic [7:0] pin_function_code; // Pin function guard contents.
    logic [7:0] threshold_code; // Threshold select contents.
    logic [3:0] trip_flags; // Sticky trip flags.
    rsc_state_t state; // Sequencer state.
    logic clear_mode; // Shared pin acts as external clear input.
    logic pin_code_bad; // Pin function code is neither valid code.
    logic thr_code_bad; // Threshold code is none of the four.
    logic pin_reset; // Clear pin is low while in clear mode.
    logic uv_trip; // Debounced undervoltage event.
    logic pin_trip; // Guard delay expired for the pin code.
    logic thr_trip; // Guard delay expired for the threshold code.
    logic wdog_trip; // Guard delay expired for the watchdog code.
    logic hold_is_short; // Current hold was started by the clear pin.
    logic pin_held; // Clear-pin reset persists until the pin goes high again.
    logic wr_fire; // Write address and data both captured and no response pending.
    logic [3:0] wr_addr; // Latched write address.
    logic [31:0] wr_data; // Latched write data.
    logic aw_held; // Write address captured.
    logic w_held; // Write data captured.

    assign clear_mode = (pin_function_code == PIN_CODE_CLEAR);
    assign pin_code_bad = !clear_mode && (pin_function_code != PIN_CODE_IO);
    assign thr_code_bad = !(threshold_code inside
        {THR_CODE_2V10, THR_CODE_2V55, THR_CODE_3V15, THR_CODE_3V80});
    assign pin_reset = clear_mode && !clr_sync[1];
    // The pin code falls back to I/O on the reset itself, so the pin is then watched on its
    // own until it rises; otherwise the hold would start while the pin is still low.
    assign pin_held = hold_is_short && (state == RSC_RESET) && !clr_sync[1];
    assign wr_fire = aw_held && w_held && !S_AXI_BVALID;

    // ------------------------------------------------------------
    // Guard trip delay counters
    // ------------------------------------------------------------
    logic [15:0] guard_cnt [3]; // One counter per protected code.
    logic [2:0] guard_bad; // Invalid-code condition per counter.
    logic [2:0] guard_hit; // Counter expiry per protected code.
    assign guard_bad = {WATCHDOG_CODE_BAD, thr_code_bad, pin_code_bad};
    assign {wdog_trip, thr_trip, pin_trip} = guard_hit;

    // Each counter starts on an invalid code and trips the reset when it expires.
    for (genvar g = 0; g < 3; g++)
    begin : gen_guard
        always_ff @(posedge MCLK)
        begin
            if (!RSTN || state != RSC_RUN || !guard_bad[g])
            begin
                guard_cnt[g] <= 16'h0000;
            end
            else if (guard_cnt[g] != 16'(GUARD_TRIP))
            begin
                guard_cnt[g] <= guard_cnt[g] + 16'h0001;
            end
        end
        assign guard_hit[g] = (guard_cnt[g] == 16'(GUARD_TRIP));
    end

    // ------------------------------------------------------------
    // Undervoltage debounce
    // ------------------------------------------------------------
    logic [15:0] uv_cnt; // Cycles the low supply has persisted.

    // Dips shorter than the debounce are ignored; power-down stops detection.
    always_ff @(posedge MCLK)
    begin
        if (!RSTN || POWER_DOWN || !low_sync[1] || state != RSC_RUN)
        begin
            uv_cnt <= 16'h0000;
        end
        else if (uv_cnt != 16'(DEBOUNCE))
        begin
            uv_cnt <= uv_cnt + 16'h0001;
        end
    end
    // The count stays at its end value for one cycle after the trip; gating by the run
    // state keeps that stale count from firing a second time.
    assign uv_trip = (uv_cnt == 16'(DEBOUNCE)) && (state == RSC_RUN);

    // ------------------------------------------------------------
    // Reset sequencer
    // ------------------------------------------------------------
    logic [31:0] hold_cnt; // Start-up hold counter.
    logic any_trip; // Any internal reset cause this cycle.
    assign any_trip = uv_trip || pin_trip || thr_trip || wdog_trip || WATCHDOG_TIMEOUT;

    // Reset lasts while the pin is low; then the hold timer runs before release.
    always_ff @(posedge MCLK)
    begin
        if (!RSTN)
        begin
            state <= RSC_RESET;
            hold_cnt <= 32'h0;
            hold_is_short <= 1'b0;
        end
        else if (pin_reset || pin_held)
        begin
            state <= RSC_RESET;
            hold_cnt <= 32'h0;
            hold_is_short <= 1'b1;
        end
        else
        begin
            case (state)
                RSC_RESET:
                begin
                    state <= RSC_HOLD;
                    hold_cnt <= 32'h0;
                end
                RSC_HOLD:
                begin
                    if (hold_cnt == 32'(hold_is_short ? HOLD_SHORT - 1 : HOLD_LONG - 1))
                    begin
                        state <= RSC_RUN;
                    end
                    hold_cnt <= hold_cnt + 32'h1;
                end
                RSC_RUN:
                begin
                    if (any_trip)
                    begin
                        state <= RSC_RESET;
                        hold_is_short <= 1'b0;
                    end
                end
                default:
                begin
                    state <= RSC_RESET;
                end
            endcase
        end
    end

    // Core reset, program counter clear and port initialisation outputs.
    always_ff @(posedge MCLK)
    begin
        if (!RSTN)
        begin
            CORE_RESET_N <= 1'b0;
            PC_CLEAR <= 1'b1;
            PORT_INIT <= 1'b1;
            PORT_INIT_VALUE <= PORT_RESET;
        end
        else
        begin
            CORE_RESET_N <= (state == RSC_RUN) && !any_trip && !pin_reset;
            PC_CLEAR <= (state != RSC_RUN) || any_trip || pin_reset;
            // Only power-on initialises ports; other resets leave them alone.
            PORT_INIT <= 1'b0;
            PORT_INIT_VALUE <= PORT_RESET;
        end
    end

    // ------------------------------------------------------------
    // Register write path and protected registers
    // ------------------------------------------------------------
    // The pin code falls back to its default on any reset but the watchdog warm reset; the threshold code only on power-on and its own trip.
    always_ff @(posedge MCLK)
    begin
        if (!RSTN)
        begin
            pin_function_code <= PIN_GUARD_RESET;
            threshold_code <= THR_RESET;
        end
        else
        begin
            if (state == RSC_RUN && (pin_trip || thr_trip || wdog_trip || uv_trip || pin_reset))
            begin
                pin_function_code <= PIN_GUARD_RESET;
            end
            else if (wr_fire && wr_addr == ADDR_PIN_GUARD && S_AXI_WSTRB[0])
            begin
                pin_function_code <= wr_data[7:0];
            end
            if (thr_trip)
            begin
                threshold_code <= THR_RESET;
            end
            else if (wr_fire && wr_addr == ADDR_THRESHOLD && S_AXI_WSTRB[0])
            begin
                threshold_code <= wr_data[7:0];
            end
        end
    end

    // Flags set by hardware; software writes zero to clear; a set wins over a clear.
    always_ff @(posedge MCLK)
    begin
        if (!RSTN)
        begin
            trip_flags <= 4'h0;
        end
        else
        begin
            for (int i = 0; i < 4; i++)
            begin
                if (wr_fire && wr_addr == ADDR_TRIP_FLAGS && S_AXI_WSTRB[0] && !wr_data[i])
                begin
                    trip_flags[i] <= 1'b0;
                end
            end
            if (pin_trip && state == RSC_RUN)
                trip_flags[FLAG_PIN_BIT] <= 1'b1;
            if (uv_trip)
                trip_flags[FLAG_UV_BIT] <= 1'b1;
            if (thr_trip && state == RSC_RUN)
                trip_flags[FLAG_THR_BIT] <= 1'b1;
            if (wdog_trip && state == RSC_RUN)
                trip_flags[FLAG_WDOG_BIT] <= 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Pin muxing and threshold level
    // ------------------------------------------------------------
    // Clear mode wins over any other pin-sharing function and floats the pin.
    always_ff @(posedge MCLK)
    begin
        if (!RSTN)
        begin
            PIN_OUT <= 1'b0;
            PIN_OE <= 1'b0;
            THRESHOLD_LEVEL <= 2'd0;
        end
        else
        begin
            PIN_OUT <= clear_mode ? 1'b0 : PIN_SHARE_OUT;
            PIN_OE <= clear_mode ? 1'b0 : PIN_SHARE_OE;
            case (threshold_code)
                THR_CODE_2V55: THRESHOLD_LEVEL <= 2'd1;
                THR_CODE_3V15: THRESHOLD_LEVEL <= 2'd2;
                THR_CODE_3V80: THRESHOLD_LEVEL <= 2'd3;
                default: THRESHOLD_LEVEL <= 2'd0;
            endcase
        end
    end

    // ------------------------------------------------------------
    // AXI4-Lite slave
    // ------------------------------------------------------------
    // Address and data are captured independently; the response follows both.
    always_ff @(posedge MCLK)
    begin
        if (!RSTN)
        begin
            aw_held <= 1'b0;
            w_held <= 1'b0;
            wr_addr <= 4'h0;
            wr_data <= 32'h0;
            S_AXI_AWREADY <= 1'b0;
            S_AXI_WREADY <= 1'b0;
            S_AXI_BVALID <= 1'b0;
            S_AXI_BRESP <= 2'b00;
        end
        else
        begin
            S_AXI_AWREADY <= !aw_held && !S_AXI_AWREADY && !S_AXI_BVALID;
            S_AXI_WREADY <= !w_held && !S_AXI_WREADY && !S_AXI_BVALID;
            if (S_AXI_AWVALID && S_AXI_AWREADY)
            begin
                aw_held <= 1'b1;
                wr_addr <= S_AXI_AWADDR;
            end
            if (S_AXI_WVALID && S_AXI_WREADY)
            begin
                w_held <= 1'b1;
                wr_data <= S_AXI_WDATA;
            end
            if (wr_fire)
            begin
                aw_held <= 1'b0;
                w_held <= 1'b0;
                S_AXI_BVALID <= 1'b1;
                // Unmapped or read-only addresses answer SLVERR.
                S_AXI_BRESP <= (wr_addr == ADDR_PIN_GUARD || wr_addr == ADDR_TRIP_FLAGS
                    || wr_addr == ADDR_THRESHOLD) ? 2'b00 : 2'b10;
            end
            else if (S_AXI_BVALID && S_AXI_BREADY)
            begin
                S_AXI_BVALID <= 1'b0;
            end
        end
    end

    // Reads return one cycle after the address is taken.
    always_ff @(posedge MCLK)
    begin
        if (!RSTN)
        begin
            S_AXI_ARREADY <= 1'b0;
            S_AXI_RVALID <= 1'b0;
            S_AXI_RDATA <= 32'h0;
            S_AXI_RRESP <= 2'b00;
        end
        else
        begin
            S_AXI_ARREADY <= !S_AXI_ARREADY && !S_AXI_RVALID && S_AXI_ARVALID;
            if (S_AXI_ARVALID && S_AXI_ARREADY)
            begin
                S_AXI_RVALID <= 1'b1;
                S_AXI_RRESP <= 2'b00;
                case (S_AXI_ARADDR)
                    ADDR_PIN_GUARD: S_AXI_RDATA <= {24'h0, pin_function_code};
                    ADDR_TRIP_FLAGS: S_AXI_RDATA <= {28'h0, trip_flags};
                    ADDR_THRESHOLD: S_AXI_RDATA <= {24'h0, threshold_code};
                    ADDR_STATUS: S_AXI_RDATA <= {29'h0, hold_is_short, state};
                    default:
                    begin
                        S_AXI_RDATA <= 32'h0;
                        S_AXI_RRESP <= 2'b10;
                    end
                endcase
            end
            else if (S_AXI_RVALID && S_AXI_RREADY)
            begin
                S_AXI_RVALID <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    a_pin_flag_set: assert property (@(posedge MCLK) disable iff (!RSTN)
        (pin_trip && state == RSC_RUN) |=> trip_flags[FLAG_PIN_BIT])
        else $error("pin code trip flag not set");
    a_uv_flag_set: assert property (@(posedge MCLK) disable iff (!RSTN)
        uv_trip |=> trip_flags[FLAG_UV_BIT] && state == RSC_RESET)
        else $error("undervoltage trip did not reset or flag");
    a_thr_restore: assert property (@(posedge MCLK) disable iff (!RSTN)
        thr_trip |=> threshold_code == THR_RESET && trip_flags[FLAG_THR_BIT])
        else $error("threshold code not restored");
    a_wdog_flag: assert property (@(posedge MCLK) disable iff (!RSTN)
        (wdog_trip && state == RSC_RUN) |=> trip_flags[FLAG_WDOG_BIT])
        else $error("watchdog code trip flag not set");
    a_upper_zero: assert property (@(posedge MCLK) disable iff (!RSTN)
        (S_AXI_RVALID && $past(S_AXI_ARADDR) == ADDR_TRIP_FLAGS && $rose(S_AXI_RVALID))
        |-> S_AXI_RDATA[31:4] == 28'h0)
        else $error("trip flag upper bits not zero");
    a_clear_override: assert property (@(posedge MCLK) disable iff (!RSTN)
        clear_mode |=> !PIN_OE)
        else $error("pin driven in clear mode");
    a_clear_reset: assert property (@(posedge MCLK) disable iff (!RSTN)
        pin_reset |=> state == RSC_RESET ##1 !CORE_RESET_N && PC_CLEAR)
        else $error("clear pin did not reset core");
    a_guard_delay: assert property (@(posedge MCLK) disable iff (!RSTN)
        (state == RSC_RUN && $rose(pin_code_bad)) |-> !pin_trip [*3])
        else $error("guard trip too early");
    a_pd_no_uv: assert property (@(posedge MCLK) disable iff (!RSTN)
        POWER_DOWN |=> uv_cnt == 16'h0000)
        else $error("undervoltage detection active in power-down");
    a_thr_keep: assert property (@(posedge MCLK) disable iff (!RSTN)
        (uv_trip && !thr_trip && !wr_fire) |=> $stable(threshold_code))
        else $error("threshold changed on undervoltage reset");

endmodule

// [bench/rsc_far_side.sv]
// Model of the far side: the external clear circuit and the supply monitor.
`timescale 1ns/100ps
module rsc_far_side (
    input wire logic mclk,
    output logic clr_n = '1, // A released pin rests high on its pull-up.
    output logic low = '0
);
    // The pin is pulled low for n cycles, then the pull-up takes it back.
    task automatic press(input int n);
        @(posedge mclk) clr_n <= '0;
        repeat (n) @(posedge mclk);
        clr_n <= '1;
    endtask
    // The supply sags below the threshold for n cycles.
    task automatic dip(input int n);
        @(posedge mclk) low <= '1;
        repeat (n) @(posedge mclk);
        low <= '0;
    endtask
endmodule

// [bench/reset_source_controller_tb.sv]
// Self-checking testbench of the reset source controller.
`timescale 1ns/100ps
module reset_source_controller_tb;
    import rsc_pkg::*;
    localparam int HL = 100; // Short holds keep the run brief.
    localparam int HS = 40;
    logic MCLK = '0, RSTN = '0, POWER_DOWN = '0, WATCHDOG_CODE_BAD = '0, WATCHDOG_TIMEOUT = '0;
    logic PIN_SHARE_OUT = '1, PIN_SHARE_OE = '1, S_AXI_AWVALID = '0, S_AXI_WVALID = '0;
    logic S_AXI_BREADY = '0, S_AXI_ARVALID = '0, S_AXI_RREADY = '0;
    logic [3:0] S_AXI_AWADDR = '0, S_AXI_ARADDR = '0, S_AXI_WSTRB = 4'h1;
    logic [31:0] S_AXI_WDATA = '0, S_AXI_RDATA;
    logic S_AXI_AWREADY, S_AXI_WREADY, S_AXI_BVALID, S_AXI_ARREADY, S_AXI_RVALID;
    logic [1:0] S_AXI_BRESP, S_AXI_RRESP, THRESHOLD_LEVEL;
    logic CORE_RESET_N, PC_CLEAR, PORT_INIT, PIN_OUT, PIN_OE, EXTERNAL_CLEAR_PIN_N, SUPPLY_LOW;
    logic [7:0] PORT_INIT_VALUE;
    int error_cnt = 0, n_compared = 0;
    rsc_reset_controller #(.HOLD_LONG(HL), .HOLD_SHORT(HS)) i_dut (.*);
    rsc_far_side i_far (.mclk(MCLK), .clr_n(EXTERNAL_CLEAR_PIN_N), .low(SUPPLY_LOW));
    always #2 MCLK = ~MCLK;
    task automatic chk(input logic [31:0] g, e);
        n_compared++;
        if (g !== e)
        begin
            error_cnt++;
            $display("unexpected at %0t: got %h expected %h", $time, g, e);
        end
    endtask
    // Write one byte; address and data are released as each is taken.
    task automatic wr(input logic [3:0] a, input logic [7:0] d, input logic [1:0] r = 2'h0);
        int t = 0;
        @(posedge MCLK);
        S_AXI_AWADDR <= a;
        S_AXI_WDATA <= {24'h0, d};
        {S_AXI_AWVALID, S_AXI_WVALID, S_AXI_BREADY} <= 3'h7;
        do
        begin
            @(posedge MCLK);
            if (S_AXI_AWREADY) S_AXI_AWVALID <= '0;
            if (S_AXI_WREADY) S_AXI_WVALID <= '0;
        end while (!S_AXI_BVALID && ++t < 50);
        S_AXI_BREADY <= '0;
        chk(S_AXI_BRESP, r);
    endtask
    task automatic rd(input logic [3:0] a, input logic [7:0] e);
        int t = 0;
        @(posedge MCLK);
        S_AXI_ARADDR <= a;
        {S_AXI_ARVALID, S_AXI_RREADY} <= 2'h3;
        do
        begin
            @(posedge MCLK);
            if (S_AXI_ARREADY) S_AXI_ARVALID <= '0;
        end while (!S_AXI_RVALID && ++t < 50);
        S_AXI_RREADY <= '0;
        chk(S_AXI_RDATA, {24'h0, e});
        chk(S_AXI_RRESP, 2'h0);
    endtask
    // Wait for the core reset to reach v, and judge how long that took.
    task automatic wcore(input logic v, input int lo, hi);
        int t = 0;
        while (CORE_RESET_N !== v && t <= hi)
        begin
            @(posedge MCLK);
            t++;
        end
        chk(t >= lo && t <= hi, 1);
    endtask
    task automatic t_levels();
        logic [7:0] c[4] = '{THR_CODE_2V10, THR_CODE_2V55, THR_CODE_3V15, THR_CODE_3V80};
        for (int i = 0; i < 4; i++)
        begin
            wr(ADDR_THRESHOLD, c[i]);
            @(posedge MCLK); // The level output follows the code one cycle later.
            chk(THRESHOLD_LEVEL, i);
        end
        wr(ADDR_STATUS, 8'h0, 2'h2);
        $display("threshold levels done");
    endtask
    task automatic t_uv();
        i_far.dip(30);
        repeat (8) @(posedge MCLK);
        chk(CORE_RESET_N, 1);
        POWER_DOWN <= '1;
        i_far.dip(100);
        chk(CORE_RESET_N, 1);
        POWER_DOWN <= '0;
        i_far.dip(100);
        chk(CORE_RESET_N, 0);
        wcore(1, HL - 40, HL + 10);
        rd(ADDR_THRESHOLD, THR_CODE_3V80);
        rd(ADDR_TRIP_FLAGS, 8'h4);
        wr(ADDR_TRIP_FLAGS, 8'h0);
        $display("undervoltage done");
    endtask
    task automatic t_pin();
        chk({PIN_OE, PIN_OUT}, 3);
        wr(ADDR_PIN_GUARD, PIN_CODE_CLEAR);
        repeat (2) @(posedge MCLK);
        chk({PIN_OE, PIN_OUT}, 0);
        // A watchdog warm reset must leave the clear-pin selection in place.
        WATCHDOG_TIMEOUT <= '1;
        @(posedge MCLK) WATCHDOG_TIMEOUT <= '0;
        wcore(0, 0, 4);
        wcore(1, HL, HL + 10);
        rd(ADDR_PIN_GUARD, PIN_CODE_CLEAR);
        i_far.press(20);
        chk({CORE_RESET_N, PC_CLEAR}, 1);
        wcore(1, HS, HS + 10);
        rd(ADDR_STATUS, 8'h7);
        rd(ADDR_PIN_GUARD, PIN_CODE_IO);
        rd(ADDR_THRESHOLD, THR_CODE_3V80);
        $display("clear pin done");
    endtask
    // A bad protected code, or a bad watchdog code for bit 0, trips a reset.
    task automatic t_trip(input logic [3:0] a, input int b);
        if (b == 0) WATCHDOG_CODE_BAD <= '1;
        else wr(a, 8'h12);
        wcore(0, b ? GUARD_TRIP_CYC - 2 : 0, GUARD_TRIP_CYC + 8);
        WATCHDOG_CODE_BAD <= '0;
        wcore(1, HL, HL + 10);
        rd(a, 8'h55);
        rd(ADDR_TRIP_FLAGS, 8'h1 << b);
        wr(ADDR_TRIP_FLAGS, 8'h0);
        rd(ADDR_TRIP_FLAGS, 8'h0);
        $display("trip %0d done", b);
    endtask
    task automatic finish_test();
        $display("compared %0d, mismatches %0d", n_compared, error_cnt);
        if (error_cnt == 0 && n_compared > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    initial
    begin
        repeat (10) @(posedge MCLK);
        chk({PORT_INIT, PORT_INIT_VALUE, PC_CLEAR, CORE_RESET_N}, 11'h7fe);
        RSTN <= '1;
        wcore(1, HL, HL + 10);
        rd(ADDR_PIN_GUARD, PIN_GUARD_RESET);
        rd(ADDR_THRESHOLD, THR_RESET);
        t_levels();
        t_uv();
        t_pin();
        t_trip(ADDR_PIN_GUARD, FLAG_PIN_BIT);
        t_trip(ADDR_THRESHOLD, FLAG_THR_BIT);
        t_trip(ADDR_PIN_GUARD, FLAG_WDOG_BIT);
        finish_test();
    end
    // A hang is cut short well past the thousand or so cycles the tests need.
    initial
    begin
        #200000;
        error_cnt++;
        finish_test();
    end
endmodule
